// >>> rtl/ivu_pkg.sv
// What this block does
// - Sample flags at state5_phase2, poll next cycle.
// - Equal or higher level in service blocks call.
// - Call only in instruction's last cycle.
// - Exit or enable/priority write defers one instruction.
// - Blocked requests are not remembered.
// - Polling order only breaks same-level ties.
// - Acknowledge by forced long call, status unsaved.
// - Vector at 0x0003 plus eight per source.
// - Vectoring clears timer 0/1 and external flags, pins 0/1 in edge mode only.
// - Interrupt exit clears current in-service level.
// - Plain subroutine exit leaves in-service state.
// - External pins inverted and latched at state5_phase2.
// - Timer, serial flags set at state5_phase2.
// - Timer 2 overflow set state2_phase2, same-cycle poll.
// - Call lasts two machine cycles.
// - Instruction blocking adds three or five cycles.
// - Single-source response between three and nine.
// - Higher request preempts right after low vectoring.
// - Two priority bits give four levels.
// - Only strictly higher level preempts.
// - Fixed within-level polling order.
// - Individual and global enable both required.
package ivu_pkg;

  localparam int SRC_N = 15;
  localparam int LVL_N = 4;

  // Source indices, in vector order.
  localparam int SRC_EXT0   = 0;
  localparam int SRC_TMR0   = 1;
  localparam int SRC_EXT1   = 2;
  localparam int SRC_TMR1   = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_TMR2   = 5;
  localparam int SRC_ARRAY  = 6;
  localparam int SRC_ADC    = 7;
  localparam int SRC_ARRAY2 = 8;
  localparam int SRC_SEP    = 9;
  localparam int SRC_EXT2   = 10;
  localparam int EXT_N      = 7;

  localparam logic [15:0] VEC_BASE  = 16'h0003;
  localparam int          VEC_SHIFT = 3;

  // Flags cleared unconditionally when vectored.
  localparam logic [14:0] HW_CLR_MASK = 15'h7C0A;

  // Polling rank to source index, rank 0 wins ties.
  localparam logic [14:0][3:0] POLL_ORDER = {
    4'hE, 4'h5, 4'h4, 4'h6, 4'hD, 4'h3, 4'hC, 4'h7,
    4'h2, 4'hB, 4'h8, 4'h1, 4'hA, 4'h9, 4'h0};

  typedef enum logic [2:0] {
    ST_POLL  = 3'b001,
    ST_CALL1 = 3'b010,
    ST_CALL2 = 3'b100
  } ivu_state_t;

  typedef struct packed {
    logic last_cycle;
    logic exit_or_cfg_write;
    logic interrupt_exit_instr;
  } ivu_core_t;

  typedef struct packed {
    logic        global_int_enable;
    logic [14:0] int_enable_reg;
    logic [14:0] int_priority_reg;
    logic [14:0] int_priority_high;
    logic [1:0]  ext_edge_mode;
  } ivu_cfg_t;

  typedef struct packed {
    logic timer0_overflow;
    logic timer1_overflow;
    logic serial_req;
    logic timer2_external_flag;
    logic timer2_overflow_flag;
    logic array_req;
    logic adc_done_flag;
    logic array2_req;
    logic expansion_port_flag;
  } ivu_periph_t;

endpackage : ivu_pkg

// >>> rtl/ivu_top.sv
`timescale 1ns/1ps
`default_nettype none

module ivu_top (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Machine-cycle phase enables
  input  wire logic                 state5_phase2,
  input  wire logic                 state2_phase2,
  // Core status and configuration
  input  wire ivu_pkg::ivu_core_t   core,
  input  wire ivu_pkg::ivu_cfg_t    cfg,
  // Request sources
  input  wire logic [6:0]           ext_request_n,
  input  wire ivu_pkg::ivu_periph_t periph,
  // Call to the core
  output logic                      forced_long_call,
  output logic [15:0]               vector_addr,
  // Status
  output logic [3:0]                in_progress,
  output logic [14:0]               hw_flag
);
  import ivu_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    ivu_state_t  fsm;
    logic [6:0]  pin_s1;
    logic [6:0]  pin_s2;
    logic [6:0]  pin_prev;
    logic [14:0] flag;
    logic [14:0] samp;
    logic        samp_tf2;
    logic [3:0]  in_prog;
    logic        call;
    logic [15:0] vector;
  } ivu_reg_t;

  ivu_reg_t st;
  ivu_reg_t next_st;

  // ****************************************************
  // Per-source priority level
  // ****************************************************
  logic [14:0][1:0] src_lvl;

  for (genvar i = 0; i < SRC_N; i++) begin : g_lvl
    assign src_lvl[i] = {cfg.int_priority_high[i],
                         cfg.int_priority_reg[i]};
  end

  // Walk the polling order from last rank to first so that an
  // equal level found later in the walk (an earlier rank) wins.
  function automatic logic [4:0] pick(
    input logic [14:0]      req,
    input logic [14:0][1:0] lvl
  );
    logic       found;
    logic [1:0] best;
    logic [3:0] sel;
    logic [3:0] idx;
    found = 1'b0;
    best  = 2'd0;
    sel   = 4'd0;
    for (int r = SRC_N - 1; r >= 0; r--) begin
      idx = POLL_ORDER[r];
      if (req[idx] && (!found || lvl[idx] >= best)) begin
        found = 1'b1;
        best  = lvl[idx];
        sel   = idx;
      end
    end
    return {found, sel};
  endfunction : pick

  // Highest in-service level, as a one-hot mask.
  function automatic logic [3:0] top_bit(input logic [3:0] v);
    logic [3:0] m;
    m = 4'h0;
    for (int k = 0; k < LVL_N; k++) begin
      if (v[k]) begin
        m = 4'h0;
        m[k] = 1'b1;
      end
    end
    return m;
  endfunction : top_bit

  // ****************************************************
  // Next state
  // ****************************************************
  logic [6:0]  act;
  logic [14:0] live;
  logic [14:0] polled;
  logic [14:0] elig;
  logic [4:0]  win;
  logic [1:0]  win_lvl;
  logic [3:0]  ip_top;
  logic [1:0]  ip_lvl;
  logic        blocked;
  logic        grant;
  logic [14:0] clr;

  always_comb begin
    next_st = st;
    // Second stage only; the first stage feeds nothing else.
    next_st.pin_s1 = ext_request_n;
    next_st.pin_s2 = st.pin_s1;
    act = ~st.pin_s2;

    // Flags held by peripherals are sampled as levels.
    live = st.flag;
    live[SRC_SERIAL] = periph.serial_req;
    live[SRC_TMR2]   = periph.timer2_external_flag;
    live[SRC_ARRAY]  = periph.array_req;
    live[SRC_ADC]    = periph.adc_done_flag;
    live[SRC_ARRAY2] = periph.array2_req;
    live[SRC_SEP]    = periph.expansion_port_flag;

    // Timer 2 overflow joins in the cycle it was caught.
    polled = st.samp;
    polled[SRC_TMR2] = st.samp[SRC_TMR2] | st.samp_tf2;

    elig = polled & cfg.int_enable_reg
         & {SRC_N{cfg.global_int_enable}};
    win     = pick(elig, src_lvl);
    win_lvl = src_lvl[win[3:0]];

    ip_top = top_bit(st.in_prog);
    ip_lvl = 2'd0;
    for (int k = 0; k < LVL_N; k++) begin
      if (ip_top[k]) begin
        ip_lvl = 2'(k);
      end
    end

    blocked = 1'b0;
    if ((st.in_prog != 4'h0) && (win_lvl <= ip_lvl)) begin
      blocked = 1'b1;
    end
    if (!core.last_cycle) begin
      blocked = 1'b1;
    end
    if (core.exit_or_cfg_write) begin
      blocked = 1'b1;
    end
    if (st.fsm != ST_POLL) begin
      blocked = 1'b1;
    end
    grant = state5_phase2 && win[4] && !blocked;

    if (state2_phase2) begin
      next_st.samp_tf2 = periph.timer2_overflow_flag;
    end

    // Interrupt exit releases the top level; a plain return
    // reaches no input here, so it cannot release it.
    if (core.interrupt_exit_instr) begin
      next_st.in_prog = st.in_prog & ~ip_top;
    end

    clr = 15'h0000;
    if (grant) begin
      clr = HW_CLR_MASK;
      clr[SRC_EXT0] = cfg.ext_edge_mode[0];
      clr[SRC_EXT1] = cfg.ext_edge_mode[1];
      clr = clr & (15'h0001 << win[3:0]);
      next_st.in_prog[win_lvl] = 1'b1;
      next_st.vector = VEC_BASE
        + 16'({win[3:0], 3'b000});
      next_st.call = 1'b1;
      next_st.fsm  = ST_CALL1;
    end
    next_st.flag = st.flag & ~clr;

    if (state5_phase2) begin
      // Samples are replaced every cycle, nothing carries over.
      next_st.samp     = live;
      next_st.pin_prev = act;
      // Level mode tracks the pin; edge mode catches a fall.
      for (int e = 0; e < 2; e++) begin
        if (cfg.ext_edge_mode[e]) begin
          if (act[e] && !st.pin_prev[e]) begin
            next_st.flag[2 * e] = 1'b1;
          end
        end else begin
          next_st.flag[2 * e] = act[e];
        end
      end
      for (int e = 2; e < EXT_N; e++) begin
        if (act[e]) begin
          next_st.flag[SRC_EXT2 + e - 2] = 1'b1;
        end
      end
      // Set wins over the vectoring clear in the same cycle.
      if (periph.timer0_overflow) begin
        next_st.flag[SRC_TMR0] = 1'b1;
      end
      if (periph.timer1_overflow) begin
        next_st.flag[SRC_TMR1] = 1'b1;
      end
      // The call spans the two machine cycles after polling.
      case (st.fsm)
        ST_POLL: begin
        end
        ST_CALL1: begin
          next_st.fsm = ST_CALL2;
        end
        ST_CALL2: begin
          next_st.fsm  = ST_POLL;
          next_st.call = 1'b0;
        end
        default: begin
          next_st.fsm  = ST_POLL;
          next_st.call = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st          <= '0;
      st.fsm      <= ST_POLL;
      st.pin_s1   <= 7'h7F;
      st.pin_s2   <= 7'h7F;
      st.vector   <= VEC_BASE;
    end else begin
      st <= next_st;
    end
  end

  assign forced_long_call = st.call;
  assign vector_addr      = st.vector;
  assign in_progress      = st.in_prog;
  assign hw_flag          = st.flag;

endmodule : ivu_top

`default_nettype wire

// >>> testbench/ivu_props.sv
`timescale 1ns/1ps
`default_nettype none
module ivu_props
  import ivu_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        state5_phase2,
  input wire ivu_core_t   core,
  input wire ivu_cfg_t    cfg,
  input wire ivu_periph_t periph,
  input wire logic        forced_long_call,
  input wire logic [15:0] vector_addr,
  input wire logic [3:0]  in_progress,
  input wire logic [14:0] hw_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [1:0] s5_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) s5_cnt <= 2'h0;
    else if (!forced_long_call) s5_cnt <= 2'h0;
    else if (state5_phase2) s5_cnt <= s5_cnt + 2'h1;
  end
  sequence s_call_start;
    !forced_long_call ##1 forced_long_call;
  endsequence
  call_gate_a: assert property (
    s_call_start |-> $past(state5_phase2 && core.last_cycle
    && !core.exit_or_cfg_write)) else $error("call off decision");
  call_enable_a: assert property (
    s_call_start |-> $past(cfg.global_int_enable))
    else $error("call while disabled");
  vector_form_a: assert property (
    s_call_start |-> vector_addr[2:0] == 3'h3
    && vector_addr <= 16'h0073) else $error("bad vector");
  vector_hold_a: assert property (
    !state5_phase2 |=> $stable(vector_addr)) else $error("vector moved");
  call_length_a: assert property (
    $fell(forced_long_call) |-> s5_cnt == 2'h2)
    else $error("call length wrong");
  level_set_a: assert property (
    s_call_start |-> in_progress != 4'h0) else $error("no level set");
  exit_clear_a: assert property (
    core.interrupt_exit_instr && !state5_phase2 && in_progress != 4'h0
    |=> $countones(in_progress) + 1 == $countones($past(in_progress))
    && (in_progress & ~$past(in_progress)) == 4'h0)
    else $error("exit did not clear");
  level_hold_a: assert property (
    !core.interrupt_exit_instr && !state5_phase2 |=> $stable(in_progress))
    else $error("level changed");
  top_level_a: assert property (
    in_progress[3] |=> !$rose(forced_long_call)) else $error("top preempted");
  timer_clear_a: assert property (
    s_call_start ##0 (vector_addr == 16'h000B
    && !$past(periph.timer0_overflow)) |-> !hw_flag[1])
    else $error("timer flag kept");
endmodule : ivu_props
bind ivu_top ivu_props u_props (.clk, .sys_rst, .state5_phase2, .core,
  .cfg, .periph, .forced_long_call, .vector_addr, .in_progress, .hw_flag);
`default_nettype wire

// >>> testbench/ivu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ivu_core_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] len_m1,
  output logic            state5_phase2,
  output logic            state2_phase2,
  output logic            last_cycle
);
  logic [2:0] phase;
  logic [1:0] mc;
  // Six clocks to a machine cycle keep the run short.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 3'h0;
      mc    <= 2'h0;
    end else begin
      phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
      if (phase == 3'h5) mc <= last_cycle ? 2'h0 : mc + 2'h1;
    end
  end
  assign state2_phase2 = (phase == 3'h1);
  assign state5_phase2 = (phase == 3'h4);
  assign last_cycle    = (mc == len_m1);
endmodule : ivu_core_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ivu_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic s5, s2, lc, call, cfg_wr, exit_p, t2sel;
  logic [1:0] len_m1;
  logic [14:0] req, hwf, m, en;
  logic [14:0][1:0] lv;
  logic [15:0] vec;
  logic [3:0] ip;
  ivu_cfg_t cfg;
  ivu_core_t core;
  ivu_periph_t periph;
  int fail_count = 0;
  int n_checks = 0;
  int n_pad;
  always #5 clk = ~clk;
  assign core = '{lc, cfg_wr, exit_p};
  // Timer 2 requests come either as the external flag or as overflow.
  assign periph = '{req[1] & s5, req[3] & s5, req[4], req[5] & ~t2sel,
                    req[5] & t2sel, req[6], req[7], req[8], req[9]};
  ivu_core_model cm (.clk, .sys_rst, .len_m1, .state5_phase2(s5),
    .state2_phase2(s2), .last_cycle(lc));
  ivu_top uut (.clk, .sys_rst, .state5_phase2(s5), .state2_phase2(s2),
    .core, .cfg, .ext_request_n(~{req[14:10], req[2], req[0]}), .periph,
    .forced_long_call(call), .vector_addr(vec), .in_progress(ip),
    .hw_flag(hwf));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask : check
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_call(input logic lvl, output int n);
    n = 0;
    while (call !== lvl && n < 200) begin
      tick();
      n++;
    end
    if (n >= 200) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : wait_call
  task automatic leave;
    req = 15'h0;
    wait_call(1'b0, n_pad);
    exit_p = 1'b1;
    tick();
    exit_p = 1'b0;
    tick();
    check("exit", 16'(ip), 16'h0);
  endtask : leave
  function automatic int winner(input logic [14:0] r, input logic [14:0][1:0] l);
    int w = -1;
    for (int k = 0; k < 15; k++) begin
      int s = POLL_ORDER[k];
      if (r[s] && (w < 0 || l[s] > l[w])) w = s;
    end
    return w;
  endfunction : winner
  task automatic fire(input int s, input logic [1:0] l);
    int n;
    logic hw;
    logic lat;
    len_m1 = 2'($urandom_range(3));
    cfg = '0;
    cfg.ext_edge_mode = 2'($urandom_range(3));
    t2sel = 1'($urandom_range(1));
    // Level-mode pins must stay active until the call is taken.
    lat = (s < 4 || s >= 10);
    hw = (s == 1 || s == 3 || s >= 10
          || (s == 0 && cfg.ext_edge_mode[0])
          || (s == 2 && cfg.ext_edge_mode[1]));
    cfg.int_enable_reg[s] = 1'b1;
    cfg.int_priority_reg[s] = l[0];
    cfg.int_priority_high[s] = l[1];
    cfg_wr = 1'b1;
    req[s] = 1'b1;
    repeat (14) tick();
    check("blocked", 16'(call), 16'h0);
    check("latched", 16'(hwf[s]), 16'(lat));
    // Let the pin release clear the synchroniser before enabling, so
    // that a set at the vectoring edge cannot re-arm the flag.
    if (hw) begin
      req[s] = 1'b0;
      repeat (2) tick();
    end
    cfg.global_int_enable = 1'b1;
    cfg_wr = 1'b0;
    wait_call(1'b1, n);
    check("response", 16'(n < 42), 16'h1);
    check("vector", vec, 16'h0003 + 16'(s * 8));
    check("level", 16'(ip), 16'(4'h1 << l));
    req = 15'h0;
    wait_call(1'b0, n);
    check("call len", 16'(n), 16'd12);
    check("hw flags", 16'(hwf), 16'h0);
    leave();
  endtask : fire
  initial begin
    {t2sel, cfg_wr, exit_p, len_m1, req, cfg} = '0;
    void'($urandom(64));
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    check("rst vec", vec, 16'h0003);
    check("rst call", 16'(call), 16'h0);
    check("rst ip", 16'(ip), 16'h0);
    check("rst flag", 16'(hwf), 16'h0);
    for (int s = 0; s < 15; s++) fire(s, 2'($urandom_range(3)));
    repeat (24) begin
      en = 15'($urandom);
      m = 15'($urandom) & 15'h03F5;
      if ((m & en) == 15'h0) {m, en} = {m | 15'h10, en | 15'h10};
      for (int s = 0; s < 15; s++) lv[s] = 2'($urandom_range(3));
      for (int s = 0; s < 15; s++) cfg.int_priority_reg[s] = lv[s][0];
      for (int s = 0; s < 15; s++) cfg.int_priority_high[s] = lv[s][1];
      cfg.int_enable_reg = en;
      cfg.ext_edge_mode = 2'h0;
      // Hold vectoring off until pins and levels are all sampled.
      cfg_wr = 1'b1;
      req = m;
      repeat (14) tick();
      cfg_wr = 1'b0;
      wait_call(1'b1, n_pad);
      check("winner", vec, 16'h0003 + 16'(winner(m & en, lv) * 8));
      leave();
    end
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
